// ===== rasd_pkg.sv
// Overview of operation
// - rotate left through carry on memory: old carry to bit 0, bit 7 to carry
// - accumulator form of left carry rotate: result to acc, memory kept, carry updated
// - plain rotate right on memory: bit 0 wraps to bit 7, no flags change
// - accumulator form of plain rotate right: result to acc only, no flags change
// - rotate right through carry on memory: old carry to bit 7, bit 0 to carry
// - accumulator form of right carry rotate: result to acc, memory kept, carry updated
// - subtract with borrow: acc plus inverted operand plus carry, four flags updated
// - subtract memory operand: acc plus inverted operand plus one, four flags updated
// - subtract immediate: acc plus inverted immediate plus one into acc, flags updated
// - taken skip discards prefetched instruction, adds dummy cycle: 2 cycles, else 1
// - decrement and skip: memory minus one written back, skip on zero, flags kept
// - accumulator decrement and skip: result to acc, memory kept, skip on zero
// - increment and skip: memory plus one written back, skip on zero, flags kept
// - accumulator increment and skip: result to acc, memory kept, skip on zero
// - bit test skip: skip when selected memory bit is one, nothing else changes
// - whole byte set: memory byte becomes FFH, no flag changes
// - single bit set: only the selected bit forced to one, flags kept
// - nibble exchange on memory: halves swapped and written back, flags kept
// - accumulator nibble exchange: swapped byte delivered to the accumulator
package rasd_pkg;
  // operation codes held in the command register
  localparam logic [4:0] OP_ROTL_CARRY = 5'h00;
  localparam logic [4:0] OP_ROTL_CARRY_TO_ACC = 5'h01;
  localparam logic [4:0] OP_ROTR_PLAIN = 5'h02;
  localparam logic [4:0] OP_ROTR_PLAIN_TO_ACC = 5'h03;
  localparam logic [4:0] OP_ROTR_CARRY = 5'h04;
  localparam logic [4:0] OP_ROTR_CARRY_TO_ACC = 5'h05;
  localparam logic [4:0] OP_MINUS_WITH_BORROW = 5'h06;
  localparam logic [4:0] OP_MINUS_WITH_BORROW_TO_MEM = 5'h07;
  localparam logic [4:0] OP_MINUS_OPERAND = 5'h08;
  localparam logic [4:0] OP_MINUS_OPERAND_TO_MEM = 5'h09;
  localparam logic [4:0] OP_MINUS_IMM = 5'h0A;
  localparam logic [4:0] OP_DECR_SKIP_ZERO = 5'h0B;
  localparam logic [4:0] OP_DECR_SKIP_ZERO_TO_ACC = 5'h0C;
  localparam logic [4:0] OP_INCR_SKIP_ZERO = 5'h0D;
  localparam logic [4:0] OP_INCR_SKIP_ZERO_TO_ACC = 5'h0E;
  localparam logic [4:0] OP_BIT_NONZERO_SKIP = 5'h0F;
  localparam logic [4:0] OP_SET_BYTE = 5'h10;
  localparam logic [4:0] OP_SET_BIT = 5'h11;
  localparam logic [4:0] OP_NIBBLE_EXCHANGE = 5'h12;
  localparam logic [4:0] OP_NIBBLE_EXCHANGE_TO_ACC = 5'h13;

  // register word indices (byte address = index * 4)
  localparam logic [5:0] REG_CMD = 6'h00;
  localparam logic [5:0] REG_ACC = 6'h01;
  localparam logic [5:0] REG_STATUS = 6'h02;
  localparam logic [5:0] REG_IMM = 6'h03;
  localparam logic [5:0] REG_CYCLES = 6'h04;
  localparam logic [5:0] REG_MEM_BASE = 6'h10;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 5;
  localparam int CMD_ADDR_LSB = 8;

  // status register fields
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_WRAP = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_SKIP = 5;

  // reset values and cycle counts
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [1:0] CYCLES_PLAIN = 2'h1;
  localparam logic [1:0] CYCLES_SKIP = 2'h2;
endpackage

// ===== rasd_alu.sv
`timescale 1ns/1ps
module rasd_alu import rasd_pkg::*; (
  input wire logic [4:0] op_i,
  input wire logic [7:0] mem_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] imm_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic carry_i,
  output logic [7:0] result_o,
  output logic carry_o,
  output logic nibble_o,
  output logic zero_o,
  output logic wrap_o,
  output logic wr_acc_o,
  output logic wr_mem_o,
  output logic upd_carry_o,
  output logic upd_arith_o,
  output logic skip_o
);
  logic [7:0] sub_b;
  logic sub_cin;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] bit_mask;

  // shared subtractor: acc + ~operand + carry-in
  always_comb begin
    sub_b = (op_i == OP_MINUS_IMM) ? imm_i : mem_i;
    sub_cin = (op_i == OP_MINUS_WITH_BORROW || op_i == OP_MINUS_WITH_BORROW_TO_MEM) ?
              carry_i : 1'b1;
    sum9 = {1'b0, acc_i} + {1'b0, ~sub_b} + {8'h00, sub_cin};
    sum5 = {1'b0, acc_i[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
    bit_mask = 8'h01 << bit_sel_i;
  end

  // operation decode and result select
  always_comb begin
    result_o = mem_i;
    carry_o = carry_i;
    nibble_o = sum5[4];
    zero_o = (sum9[7:0] == 8'h00);
    wrap_o = (acc_i[7] != sub_b[7]) && (sum9[7] != acc_i[7]);
    wr_acc_o = 1'b0;
    wr_mem_o = 1'b0;
    upd_carry_o = 1'b0;
    upd_arith_o = 1'b0;
    skip_o = 1'b0;
    case (op_i)
      OP_ROTL_CARRY, OP_ROTL_CARRY_TO_ACC: begin
        result_o = {mem_i[6:0], carry_i};
        carry_o = mem_i[7];
        upd_carry_o = 1'b1;
        wr_mem_o = (op_i == OP_ROTL_CARRY);
        wr_acc_o = (op_i == OP_ROTL_CARRY_TO_ACC);
      end
      OP_ROTR_PLAIN, OP_ROTR_PLAIN_TO_ACC: begin
        result_o = {mem_i[0], mem_i[7:1]};
        wr_mem_o = (op_i == OP_ROTR_PLAIN);
        wr_acc_o = (op_i == OP_ROTR_PLAIN_TO_ACC);
      end
      OP_ROTR_CARRY, OP_ROTR_CARRY_TO_ACC: begin
        result_o = {carry_i, mem_i[7:1]};
        carry_o = mem_i[0];
        upd_carry_o = 1'b1;
        wr_mem_o = (op_i == OP_ROTR_CARRY);
        wr_acc_o = (op_i == OP_ROTR_CARRY_TO_ACC);
      end
      OP_MINUS_WITH_BORROW, OP_MINUS_WITH_BORROW_TO_MEM, OP_MINUS_OPERAND,
      OP_MINUS_OPERAND_TO_MEM, OP_MINUS_IMM: begin
        result_o = sum9[7:0];
        carry_o = sum9[8];
        upd_carry_o = 1'b1;
        upd_arith_o = 1'b1;
        wr_mem_o = (op_i == OP_MINUS_WITH_BORROW_TO_MEM || op_i == OP_MINUS_OPERAND_TO_MEM);
        wr_acc_o = !wr_mem_o;
      end
      OP_DECR_SKIP_ZERO, OP_DECR_SKIP_ZERO_TO_ACC: begin
        result_o = mem_i - 8'h01;
        skip_o = (result_o == 8'h00);
        wr_mem_o = (op_i == OP_DECR_SKIP_ZERO);
        wr_acc_o = (op_i == OP_DECR_SKIP_ZERO_TO_ACC);
      end
      OP_INCR_SKIP_ZERO, OP_INCR_SKIP_ZERO_TO_ACC: begin
        result_o = mem_i + 8'h01;
        skip_o = (result_o == 8'h00);
        wr_mem_o = (op_i == OP_INCR_SKIP_ZERO);
        wr_acc_o = (op_i == OP_INCR_SKIP_ZERO_TO_ACC);
      end
      OP_BIT_NONZERO_SKIP: begin
        skip_o = |(mem_i & bit_mask);
      end
      OP_SET_BYTE: begin
        result_o = BYTE_ALL_ONES;
        wr_mem_o = 1'b1;
      end
      OP_SET_BIT: begin
        result_o = mem_i | bit_mask;
        wr_mem_o = 1'b1;
      end
      OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_TO_ACC: begin
        result_o = {mem_i[3:0], mem_i[7:4]};
        wr_mem_o = (op_i == OP_NIBBLE_EXCHANGE);
        wr_acc_o = (op_i == OP_NIBBLE_EXCHANGE_TO_ACC);
      end
      default: begin
        result_o = mem_i;
      end
    endcase
  end
endmodule

// ===== rasd_datapath.sv
`timescale 1ns/1ps
module rasd_datapath import rasd_pkg::*; #(
  parameter int MEM_DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic busy_o,
  output logic skip_o
);
  typedef enum logic [1:0] {
    RASD_IDLE,
    RASD_EXEC,
    RASD_DUMMY
  } rasd_state_t;

  rasd_state_t state;
  logic [7:0] mem [MEM_DEPTH];
  logic [11:0] cmd;
  logic [7:0] acc;
  logic [7:0] imm;
  logic carry;
  logic nibble_carry;
  logic zero;
  logic signed_wrap;
  logic last_skip;
  logic [1:0] cycles;
  logic [5:0] word_idx;
  logic is_mem;
  logic [3:0] sw_mem_idx;
  logic accept;
  logic sw_write;
  logic [31:0] next_readdata;
  logic [4:0] cur_op;
  logic [2:0] cur_bit;
  logic [3:0] cur_addr;
  logic [7:0] cur_mem;
  logic [7:0] alu_result;
  logic alu_carry;
  logic alu_nibble;
  logic alu_zero;
  logic alu_wrap;
  logic alu_wr_acc;
  logic alu_wr_mem;
  logic alu_upd_carry;
  logic alu_upd_arith;
  logic alu_skip;
  logic exec;

  // bus decode
  always_comb begin
    word_idx = avs_address_i[7:2];
    is_mem = (word_idx >= REG_MEM_BASE) &&
             (word_idx < REG_MEM_BASE + 6'(MEM_DEPTH));
    sw_mem_idx = 4'(word_idx - REG_MEM_BASE);
    accept = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    sw_write = accept && avs_write_i;
    exec = (state == RASD_EXEC);
  end

  // command fields
  always_comb begin
    cur_op = cmd[CMD_OP_LSB +: 5];
    cur_bit = cmd[CMD_BIT_LSB +: 3];
    cur_addr = cmd[CMD_ADDR_LSB +: 4];
    cur_mem = mem[cur_addr];
  end

  rasd_alu u_alu (
    .op_i(cur_op),
    .mem_i(cur_mem),
    .acc_i(acc),
    .imm_i(imm),
    .bit_sel_i(cur_bit),
    .carry_i(carry),
    .result_o(alu_result),
    .carry_o(alu_carry),
    .nibble_o(alu_nibble),
    .zero_o(alu_zero),
    .wrap_o(alu_wrap),
    .wr_acc_o(alu_wr_acc),
    .wr_mem_o(alu_wr_mem),
    .upd_carry_o(alu_upd_carry),
    .upd_arith_o(alu_upd_arith),
    .skip_o(alu_skip)
  );

  // waitrequest: low for one cycle per request, held high while executing
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (accept) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && state == RASD_IDLE) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // read data mux, sampled when the answer is granted
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (is_mem) begin
      next_readdata = {24'h00_0000, mem[sw_mem_idx]};
    end else begin
      case (word_idx)
        REG_CMD: next_readdata = {20'h0_0000, cmd};
        REG_ACC: next_readdata = {24'h00_0000, acc};
        REG_STATUS: next_readdata = {26'h000_0000, last_skip, 1'b0, signed_wrap, zero,
                                     nibble_carry, carry};
        REG_IMM: next_readdata = {24'h00_0000, imm};
        REG_CYCLES: next_readdata = {30'h0000_0000, cycles};
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // read data register
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o && state == RASD_IDLE) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // instruction sequencer: one exec cycle plus a dummy cycle on a taken skip
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state <= RASD_IDLE;
    end else begin
      case (state)
        RASD_IDLE: begin
          if (sw_write && !is_mem && word_idx == REG_CMD && avs_byteenable_i[0]) begin
            state <= RASD_EXEC;
          end
        end
        RASD_EXEC: begin
          state <= alu_skip ? RASD_DUMMY : RASD_IDLE;
        end
        RASD_DUMMY: begin
          state <= RASD_IDLE;
        end
        default: begin
          state <= RASD_IDLE;
        end
      endcase
    end
  end

  // busy and skip indications to the fetch logic
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      skip_o <= 1'b0;
    end else begin
      busy_o <= (state == RASD_IDLE) ?
                (sw_write && !is_mem && word_idx == REG_CMD && avs_byteenable_i[0]) :
                (exec && alu_skip);
      skip_o <= exec && alu_skip; // high during the dummy cycle
    end
  end

  // last skip outcome and instruction length
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      last_skip <= 1'b0;
      cycles <= 2'h0;
    end else if (exec) begin
      last_skip <= alu_skip;
      cycles <= alu_skip ? CYCLES_SKIP : CYCLES_PLAIN;
    end
  end

  // command register, written by software in byte lanes 0 and 1
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cmd <= 12'h000;
    end else if (sw_write && !is_mem && word_idx == REG_CMD) begin
      if (avs_byteenable_i[0]) begin
        cmd[7:0] <= avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        cmd[11:8] <= avs_writedata_i[11:8];
      end
    end
  end

  // immediate operand register
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      imm <= 8'h00;
    end else if (sw_write && !is_mem && word_idx == REG_IMM && avs_byteenable_i[0]) begin
      imm <= avs_writedata_i[7:0];
    end
  end

  // accumulator: software load or datapath result
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      acc <= ACC_RESET;
    end else if (exec && alu_wr_acc) begin
      acc <= alu_result;
    end else if (sw_write && !is_mem && word_idx == REG_ACC && avs_byteenable_i[0]) begin
      acc <= avs_writedata_i[7:0];
    end
  end

  // carry flag: rotates through carry and subtracts only
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      carry <= 1'b0;
    end else if (exec && alu_upd_carry) begin
      carry <= alu_carry;
    end else if (sw_write && !is_mem && word_idx == REG_STATUS && avs_byteenable_i[0]) begin
      carry <= avs_writedata_i[ST_CARRY];
    end
  end

  // wrap, zero and nibble carry flags: subtracts only
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      nibble_carry <= 1'b0;
      zero <= 1'b0;
      signed_wrap <= 1'b0;
    end else if (exec && alu_upd_arith) begin
      nibble_carry <= alu_nibble;
      zero <= alu_zero;
      signed_wrap <= alu_wrap;
    end else if (sw_write && !is_mem && word_idx == REG_STATUS && avs_byteenable_i[0]) begin
      nibble_carry <= avs_writedata_i[ST_NIBBLE];
      zero <= avs_writedata_i[ST_ZERO];
      signed_wrap <= avs_writedata_i[ST_WRAP];
    end
  end

  // data memory: datapath write-back or software access
  always_ff @(posedge sys_clk_i) begin
    if (exec && alu_wr_mem) begin
      mem[cur_addr] <= alu_result;
    end else if (sw_write && is_mem && avs_byteenable_i[0]) begin
      mem[sw_mem_idx] <= avs_writedata_i[7:0];
    end
  end
endmodule

// ===== rasd_datapath_checker.sv
`timescale 1ns/1ps
module rasd_datapath_checker #(
  parameter int MEM_DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic busy_o,
  input wire logic skip_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // granted write of the command word
  sequence cmd_grant;
    avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h00 && avs_byteenable_i[0];
  endsequence
  // exec cycle then dummy cycle
  sequence exec_then_skip;
    (busy_o && !skip_o) ##1 skip_o;
  endsequence
  chk_cmd_starts_exec: assert property (cmd_grant |=> busy_o && !skip_o)
    else $error("no exec cycle after command");
  chk_dummy_then_idle: assert property (exec_then_skip |-> busy_o ##1 !busy_o)
    else $error("dummy cycle not closing the skip");
  chk_skip_single: assert property (skip_o |=> !skip_o)
    else $error("skip pulse too long");
  chk_skip_after_exec: assert property (skip_o |-> $past(busy_o) && !$past(skip_o))
    else $error("skip without exec cycle");
  chk_busy_two_max: assert property (busy_o ##1 busy_o |=> !busy_o)
    else $error("instruction longer than two cycles");
  chk_second_is_skip: assert property (busy_o ##1 busy_o |-> skip_o)
    else $error("second cycle without skip");
  chk_busy_holds_bus: assert property (busy_o |-> avs_waitrequest_o)
    else $error("grant during execution");
  chk_grant_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("grant longer than one cycle");
  chk_grant_bound: assert property ($rose(avs_read_i || avs_write_i) |->
    ##[1:4] !avs_waitrequest_o)
    else $error("request not granted in time");
  cover property (exec_then_skip);
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import rasd_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic wait_req;
  logic busy;
  logic skip;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_busy = 0;
  int n_skip = 0;
  logic [7:0] mv [4] = '{8'h01, 8'hFF, 8'h96, 8'h80};
  logic [7:0] av [4] = '{8'h01, 8'h7F, 8'h80, 8'h30};
  logic [3:0] fv [4] = '{4'h0, 4'h1, 4'hE, 4'h1};
  logic [2:0] bv [4] = '{3'h0, 3'h3, 3'h5, 3'h7};

  rasd_datapath #(.MEM_DEPTH(16)) u_dut (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .avs_address_i(adr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wd),
    .avs_byteenable_i(be),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req),
    .busy_o(busy),
    .skip_o(skip)
  );

  // clock, 20 ns period
  always #10 sys_clk_i = ~sys_clk_i;

  // cycle budget, busy and skip cycle counts
  always @(posedge sys_clk_i) begin
    cyc++;
    if (busy === 1'b1) n_busy++;
    if (skip === 1'b1) n_skip++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one bus access, held until waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge sys_clk_i);
    while (wait_req !== 1'b0) @(posedge sys_clk_i);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  // reference: {skip, wrap, zero, nibble, carry, mem, acc}
  function automatic logic [20:0] model(input logic [4:0] op, input logic [2:0] b,
      input logic [7:0] m, input logic [7:0] a, input logic [7:0] i, input logic [3:0] f);
    logic [7:0] na;
    logic [7:0] nm;
    logic [3:0] nf;
    logic sk;
    logic [7:0] x;
    logic [8:0] s;
    logic [4:0] h;
    logic ci;
    na = a;
    nm = m;
    nf = f;
    sk = 1'b0;
    case (op)
      OP_ROTL_CARRY: {nf[0], nm} = {m, f[0]};
      OP_ROTL_CARRY_TO_ACC: {nf[0], na} = {m, f[0]};
      OP_ROTR_PLAIN: nm = {m[0], m[7:1]};
      OP_ROTR_PLAIN_TO_ACC: na = {m[0], m[7:1]};
      OP_ROTR_CARRY: {nm, nf[0]} = {f[0], m};
      OP_ROTR_CARRY_TO_ACC: {na, nf[0]} = {f[0], m};
      OP_DECR_SKIP_ZERO: nm = m - 8'h01;
      OP_DECR_SKIP_ZERO_TO_ACC: na = m - 8'h01;
      OP_INCR_SKIP_ZERO: nm = m + 8'h01;
      OP_INCR_SKIP_ZERO_TO_ACC: na = m + 8'h01;
      OP_BIT_NONZERO_SKIP: sk = m[b];
      OP_SET_BYTE: nm = BYTE_ALL_ONES;
      OP_SET_BIT: nm[b] = 1'b1;
      OP_NIBBLE_EXCHANGE: nm = {m[3:0], m[7:4]};
      OP_NIBBLE_EXCHANGE_TO_ACC: na = {m[3:0], m[7:4]};
      OP_MINUS_WITH_BORROW, OP_MINUS_WITH_BORROW_TO_MEM, OP_MINUS_OPERAND,
      OP_MINUS_OPERAND_TO_MEM, OP_MINUS_IMM: begin
        // subtract group
        x = (op == OP_MINUS_IMM) ? i : m;
        ci = (op inside {OP_MINUS_WITH_BORROW, OP_MINUS_WITH_BORROW_TO_MEM}) ? f[0] : 1'b1;
        s = {1'b0, a} + {1'b0, ~x} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, ~x[3:0]} + {4'h0, ci};
        nf = {(a[7] != x[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
        if (op inside {OP_MINUS_WITH_BORROW_TO_MEM, OP_MINUS_OPERAND_TO_MEM})
          nm = s[7:0];
        else
          na = s[7:0];
      end
      default: sk = 1'b0; // unused codes leave memory, acc and flags alone
    endcase
    if (op inside {OP_DECR_SKIP_ZERO, OP_INCR_SKIP_ZERO})
      sk = (nm == 8'h00);
    if (op inside {OP_DECR_SKIP_ZERO_TO_ACC, OP_INCR_SKIP_ZERO_TO_ACC})
      sk = (na == 8'h00);
    return {sk, nf, nm, na};
  endfunction

  // main sequence
  initial begin
    logic [20:0] e;
    logic [7:0] ma;
    int nb;
    int ns;
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h0);
    rchk(8'h10, 32'h0);
    wreg(8'h20, 32'h000000A5);
    rchk(8'h20, 32'h0);
    be <= 4'hE;
    wreg(8'h04, 32'h00000077);
    be <= 4'hF;
    rchk(8'h04, 32'h0);
    // every op code over four operand sets, skips taken and not
    for (int op = 0; op < 21; op++) begin
      for (int k = 0; k < 4; k++) begin
        ma = {2'b01, 4'(k * 5), 2'b00};
        e = model(5'(op), bv[k], mv[k], av[k], ~mv[k], fv[k]);
        wreg(ma, {24'h0, mv[k]});
        wreg(8'h04, {24'h0, av[k]});
        wreg(8'h08, {28'h0, fv[k]});
        wreg(8'h0C, {24'h0, ~mv[k]});
        nb = n_busy;
        ns = n_skip;
        wreg(8'h00, {20'h0, 4'(k * 5), bv[k], 5'(op)});
        rchk(8'h04, {24'h0, e[7:0]});
        rchk(ma, {24'h0, e[15:8]});
        rchk(8'h08, {26'h0, e[20], 1'b0, e[19:16]});
        rchk(8'h10, e[20] ? 32'h2 : 32'h1);
        check(32'(n_busy - nb), e[20] ? 32'h2 : 32'h1);
        check(32'(n_skip - ns), {31'h0, e[20]});
      end
    end
    print_verdict();
  end
endmodule

bind rasd_datapath rasd_datapath_checker #(.MEM_DEPTH(MEM_DEPTH)) u_chk (
  .sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .busy_o(busy_o),
  .skip_o(skip_o)
);
